// [logic/acsp_fifo.sv]
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ns
module acsp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// Storage and pointers, one extra bit tells full from empty
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop, full, empty;

	always_comb begin
		full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
		empty = (wr_q == rd_q);
		push = i_in_valid && !full;
		pop = i_out_ready && !empty;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (i_ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_ce && push) begin
			mem[wr_q[AW-1:0]] <= i_in_data;
		end
	end

	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rd_q[AW-1:0]];
endmodule

// [logic/acsp_link.sv]
// Shift-clock side: output bit selection and daisy-chain capture
`timescale 1ns/1ns
module acsp_link
	import acsp_pkg::*;
(
	// Link clock and serial input pin
	input wire logic i_sck,
	input wire logic i_sdi,
	// Core side
	acsp_link_if.link lk
);
	`include "acsp_defs.svh"

	// ==========================================================
	// Bit counter, cleared whenever no frame is open
	// The shift clock stops between frames, so the frame level clears
	// this state; no edge is needed to start a new frame at the MSB.
	logic [4:0] cnt_q, cnt_d;
	logic [15:0] chain_q, chain_d;
	logic end_q, end_d;
	logic [4:0] last;

	function automatic logic pick_bit(input logic [15:0] w,
			input logic pre, input logic [4:0] c);
		logic [4:0] idx;
		idx = 5'd0;
		if (pre && c == 5'd0) begin
			pick_bit = 1'b1;
		end else begin
			idx = pre ? 5'd16 - c : 5'd15 - c;
			pick_bit = w[idx[3:0]];
		end
	endfunction

	always_comb begin
		last = lk.busy_pre ? 5'd17 : 5'd16;
		cnt_d = (cnt_q < last) ? cnt_q + 5'd1 : cnt_q; // (R11)
		chain_d = {chain_q[14:0], i_sdi}; // (R13)
		end_d = (cnt_d == last);
	end

	always_ff @(negedge i_sck or negedge lk.frame_act) begin
		if (!lk.frame_act) begin
			cnt_q <= 5'd0;
			chain_q <= 16'h0000;
			end_q <= 1'b0;
		end else begin // (R12)
			cnt_q <= cnt_d;
			chain_q <= chain_d;
			end_q <= end_d;
		end
	end

	// ==========================================================
	// Output bit
	always_comb begin
		if (!lk.word_rdy) begin
			lk.sdo_bit = lk.chain && lk.busy_pre && i_sdi; // (R14)
		end else if (cnt_q < last) begin
			lk.sdo_bit = pick_bit(lk.word, lk.busy_pre, cnt_q); // (R09)
		end else if (lk.chain) begin
			lk.sdo_bit = chain_q[15]; // (R04)
		end else begin
			lk.sdo_bit = 1'b0;
		end
	end

	assign lk.sdo_end = end_q;
endmodule

// [logic/acsp_port.sv]
// Conversion start, mode latch, result buffer and serial output enable
//
// Behaviour
// (R01) Convert-start rising edge starts a conversion; result ready 0.7 to 3.2 us later.
// (R02) Convert-start leading edge both starts conversion and latches interface mode.
// (R03) Serial input low at that edge selects daisy-chain mode.
// (R04) In chain mode serial input reappears on output after 16 shift cycles.
// (R05) Host reads chained results while convert-start is held high.
// (R06) Serial input high at that edge selects chip-select mode.
// (R07) Chip-select mode: output driven while convert-start or serial input low.
// (R08) Chip-select mode: busy indicator armed if either pin low at completion.
// (R09) On enable in chip-select mode, result bit 15 appears first.
// (R10) Output released on both pins high or after the last falling edge.
// (R11) Each shift-clock cycle advances the result by one bit while selected.
// (R12) Serial output changes only after falling shift-clock edges.
// (R13) Chain mode captures serial input on falling shift-clock edges.
// (R14) Chain mode with busy: serial input high passes straight to output.
// (R15) Internal clock times conversion; completion returns to acquisition, busy raised.
// (R16) Result is 16-bit two's complement, saturating at 7fff and 8000.
// (R17) Host gives sixteen shift cycles per chained converter, nearest first.
`timescale 1ns/1ns
module acsp_port
	import acsp_pkg::*;
(
	// System clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Link clock from the host
	input wire logic i_sck,
	// Pins from the host
	input wire logic i_convert_start,
	input wire logic i_serial_in_mode_select,
	// Held sample from the front end, signed, wider than the result
	input wire logic signed [17:0] i_sample_level,
	// Serial output pin
	output logic o_serial_result_out,
	output logic o_serial_result_out_oe,
	// Status
	output logic o_converting
);
	`include "acsp_defs.svh"

	localparam logic [`ACSP_CONV_CNT_W-1:0] CONV_LAST =
		`ACSP_CONV_CNT_W'(`ACSP_CONV_MIN_CYC - 1);

	// ==========================================================
	// Saturating conversion to the output code
	function automatic logic [15:0] sat_code(input logic signed [17:0] v);
		if (v > 18'sh07fff) begin
			sat_code = `ACSP_CODE_POS_FS;
		end else if (v < -18'sh08000) begin
			sat_code = `ACSP_CODE_NEG_FS;
		end else begin
			sat_code = v[15:0];
		end
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic cnv_m_q, cnv_s_q, cnv_p_q;
	logic sdi_m_q, sdi_s_q;
	logic end_m_q, end_s_q;
	logic cnv_rise;

	acsp_link_if lk ();

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnv_m_q <= 1'b0;
			cnv_s_q <= 1'b0;
			cnv_p_q <= 1'b0;
			sdi_m_q <= 1'b1;
			sdi_s_q <= 1'b1;
			end_m_q <= 1'b0;
			end_s_q <= 1'b0;
		end else if (i_ce) begin
			cnv_m_q <= i_convert_start;
			cnv_s_q <= cnv_m_q;
			cnv_p_q <= cnv_s_q;
			sdi_m_q <= i_serial_in_mode_select;
			sdi_s_q <= sdi_m_q;
			end_m_q <= lk.sdo_end;
			end_s_q <= end_m_q;
		end
	end

	assign cnv_rise = cnv_s_q && !cnv_p_q;

	// ==========================================================
	// Conversion sequencer
	acsp_state_t st_q, st_d;
	acsp_mode_t mode_q, mode_d;
	logic [`ACSP_CONV_CNT_W-1:0] cc_q, cc_d;
	logic signed [17:0] held_q, held_d;
	logic [15:0] res_q, res_d;
	logic busy_q, busy_d;
	logic cs_en;
	logic f_in_ready, f_out_valid;
	logic [15:0] f_out_data;
	logic push;

	always_comb begin
		cs_en = !cnv_s_q || !sdi_s_q;
		st_d = st_q;
		mode_d = mode_q;
		cc_d = cc_q;
		held_d = held_q;
		res_d = res_q;
		busy_d = busy_q;
		push = 1'b0;
		case (st_q)
			ACSP_ST_IDLE: begin
				if (cnv_rise) begin // (R01)
					st_d = ACSP_ST_CONV;
					cc_d = '0;
					held_d = i_sample_level;
					mode_d = sdi_s_q ? ACSP_MODE_CS : ACSP_MODE_CHAIN; // (R02)
				end
			end
			ACSP_ST_CONV: begin
				// Internal clock only; the shift clock plays no part
				if (cc_q == CONV_LAST) begin // (R15)
					st_d = ACSP_ST_PUSH;
					res_d = sat_code(held_q); // (R16)
					if (mode_q == ACSP_MODE_CS) begin
						busy_d = cs_en; // (R08)
					end else begin
						busy_d = !cnv_s_q;
					end
				end else begin
					cc_d = cc_q + 1'b1;
				end
			end
			ACSP_ST_PUSH: begin
				// A full buffer holds the sequencer here, not the result
				push = 1'b1;
				if (f_in_ready) begin
					st_d = ACSP_ST_IDLE;
				end
			end
			default: begin
				st_d = ACSP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_q <= ACSP_ST_IDLE;
			mode_q <= ACSP_MODE_CS;
			cc_q <= '0;
			held_q <= '0;
			res_q <= 16'h0000;
			busy_q <= 1'b0;
		end else if (i_ce) begin
			st_q <= st_d;
			mode_q <= mode_d;
			cc_q <= cc_d;
			held_q <= held_d;
			res_q <= res_d;
			busy_q <= busy_d;
		end
	end

	// ==========================================================
	// Result buffer between conversion and serial readout
	logic pop;

	acsp_fifo #(
		.WIDTH(`ACSP_RES_W),
		.DEPTH(`ACSP_FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_valid(push),
		.o_in_ready(f_in_ready),
		.i_in_data(res_q),
		.o_out_valid(f_out_valid),
		.i_out_ready(pop),
		.o_out_data(f_out_data)
	);

	// ==========================================================
	// Word presented to the link, frame level and output enable
	// The word only changes while the shift clock stands still, so the
	// link side reads it as a static value without a further crossing.
	logic [15:0] word_q, word_d;
	logic full_q, full_d;
	logic frame_q, frame_d;
	logic oe_q, oe_d;
	logic pre_q, pre_d;
	logic chain_q, chain_d;
	logic conv_q;

	always_comb begin
		word_d = word_q;
		full_d = full_q;
		pre_d = pre_q;
		chain_d = (mode_q == ACSP_MODE_CHAIN);
		pop = 1'b0;
		if (!full_q) begin
			// An open frame still takes the word: a host that waits for
			// the busy bit gives no shift edge before the word stands
			if (f_out_valid && !end_s_q) begin
				pop = 1'b1;
				word_d = f_out_data;
				full_d = 1'b1;
				pre_d = busy_q;
			end
		end else if (frame_q && end_s_q && !chain_d) begin
			full_d = 1'b0; // (R10)
		end
		if (chain_d) begin
			// Chain frames stay open while convert-start is high
			frame_d = cnv_s_q && (st_q == ACSP_ST_IDLE) && full_q; // (R05)
			if (frame_q && !frame_d) begin
				full_d = 1'b0;
			end
			oe_d = 1'b1; // (R03)
		end else begin
			frame_d = cs_en; // (R06)
			oe_d = cs_en && !end_s_q; // (R07)
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			word_q <= 16'h0000;
			full_q <= 1'b0;
			frame_q <= 1'b0;
			oe_q <= 1'b0;
			pre_q <= 1'b0;
			chain_q <= 1'b0;
			conv_q <= 1'b0;
		end else if (i_ce) begin
			word_q <= word_d;
			full_q <= full_d;
			frame_q <= frame_d;
			oe_q <= oe_d;
			pre_q <= pre_d;
			chain_q <= chain_d;
			conv_q <= (st_d == ACSP_ST_CONV);
		end
	end

	assign lk.word = word_q;
	assign lk.word_rdy = full_q;
	assign lk.frame_act = frame_q;
	assign lk.chain = chain_q;
	assign lk.busy_pre = pre_q;

	acsp_link u_link (
		.i_sck(i_sck),
		.i_sdi(i_serial_in_mode_select),
		.lk(lk)
	);

	// ==========================================================
	// Outputs
	// The data bit is picked on the link side from registered state, or from the serial input pin in chain mode with busy;
	// it cannot be a flop of its own, since the MSB must stand before
	// the host gives any shift-clock edge.
	assign o_serial_result_out = lk.sdo_bit; // (R12)
	assign o_serial_result_out_oe = oe_q;
	assign o_converting = conv_q;
endmodule

// [pkg/acsp_defs.svh]
// Constants of the serial conversion port: widths, codes and timing counts
`ifndef ACSP_DEFS_SVH
`define ACSP_DEFS_SVH

// ==========================================================
// Data widths, buffer depth and chain delay
`define ACSP_RES_W 16
`define ACSP_RAW_W 18
`define ACSP_FIFO_DEPTH 16
`define ACSP_CHAIN_DLY 16

// ==========================================================
// Output codes at the ends of the range
`define ACSP_CODE_POS_FS 16'h7fff
`define ACSP_CODE_NEG_FS 16'h8000

// ==========================================================
// Conversion timing, system clock in MHz, times in ns
`define ACSP_CLK_MHZ 100
`define ACSP_CONV_MIN_NS 700
`define ACSP_CONV_MAX_NS 3200
`define ACSP_CONV_MIN_CYC ((`ACSP_CONV_MIN_NS * `ACSP_CLK_MHZ + 999) / 1000)
`define ACSP_CONV_MAX_CYC ((`ACSP_CONV_MAX_NS * `ACSP_CLK_MHZ) / 1000)
`define ACSP_CONV_CNT_W 9

`endif

// [pkg/acsp_link_if.sv]
// Signals between the system-clock core and the shift-clock link logic
`timescale 1ns/1ns
interface acsp_link_if;
	logic [15:0] word;
	logic word_rdy;
	logic frame_act;
	logic chain;
	logic busy_pre;
	logic sdo_bit;
	logic sdo_end;

	modport core (
		output word,
		output word_rdy,
		output frame_act,
		output chain,
		output busy_pre,
		input sdo_bit,
		input sdo_end
	);

	modport link (
		input word,
		input word_rdy,
		input frame_act,
		input chain,
		input busy_pre,
		output sdo_bit,
		output sdo_end
	);
endinterface

// [pkg/acsp_pkg.sv]
// Types shared by the serial conversion port modules
package acsp_pkg;

	// ==========================================================
	// Interface mode latched at the convert-start edge
	typedef enum logic {
		ACSP_MODE_CHAIN = 1'b0,
		ACSP_MODE_CS = 1'b1
	} acsp_mode_t;

	// ==========================================================
	// Conversion sequencer, Gray coded along idle, convert, push
	typedef enum logic [1:0] {
		ACSP_ST_IDLE = 2'b00,
		ACSP_ST_CONV = 2'b01,
		ACSP_ST_PUSH = 2'b11
	} acsp_state_t;

endpackage

// [test/acsp_host_model.sv]
// Host serial controller model: shift clock, sampling, upstream data
`timescale 1ns/1ns
module acsp_host_model (
	// Frame request
	input wire logic i_go,
	input wire logic [5:0] i_nbits,
	input wire logic [15:0] i_up_pat,
	// Pins
	input wire logic i_sout,
	input wire logic i_sout_oe,
	output logic o_sck,
	output logic o_up,
	// Result
	output logic [31:0] o_word,
	output logic o_done
);
	// ==========
	// Clock stands high between frames; upstream goes junk after 16 bits
	logic [15:0] pat;
	initial begin
		o_sck = 1'b1;
		o_up = 1'b0;
		o_word = 32'h0;
		o_done = 1'b0;
	end
	always @(posedge i_go) begin
		o_word = 32'h0;
		pat = i_up_pat;
		o_up = pat[15];
		for (int i = 0; i < int'(i_nbits); i++) begin
			o_word = {o_word[30:0], i_sout_oe ? i_sout : 1'bx};
			#6 o_sck = 1'b0;
			#6 o_sck = 1'b1;
			pat = {pat[14:0], ~pat[0]};
			o_up = pat[15];
		end
		o_done = 1'b1;
		#5 o_done = 1'b0;
	end
endmodule

// [test/acsp_port_properties.sv]
// Checker for the serial conversion port
`timescale 1ns/1ns
module acsp_port_chk (
	// Clocks, reset and pins in
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_sck,
	input wire logic i_convert_start,
	input wire logic i_serial_in_mode_select,
	input wire logic signed [17:0] i_sample_level,
	// Pins out
	input wire logic o_serial_result_out,
	input wire logic o_serial_result_out_oe,
	input wire logic o_converting
);
	// ==========
	// Trackers; rdy_q only guesses the buffer state
	logic cs_q, rdy_q;
	logic [6:0] cnt_q;
	logic [4:0] fall_q;
	logic [15:0] sh_q;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cs_q <= 1'b1;
			rdy_q <= 1'b0;
			cnt_q <= 7'h00;
		end else begin
			if ($rose(i_convert_start) && !o_converting)
				cs_q <= i_serial_in_mode_select;
			rdy_q <= i_convert_start && (rdy_q || $fell(o_converting));
			cnt_q <= o_converting ? cnt_q + 7'h01 : 7'h00;
		end
	end
	always_ff @(negedge i_sck or posedge i_rst) begin
		if (i_rst) begin
			fall_q <= 5'h00;
			sh_q <= 16'h0000;
		end else if (!cs_q) begin
			fall_q <= fall_q + {4'h0, fall_q != 5'h1f};
			sh_q <= {sh_q[14:0], i_serial_in_mode_select};
		end
	end
	conv_len_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_converting) |-> cnt_q == 7'h46) else $error("bad length");
	conv_start_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(i_convert_start) && !o_converting |-> ##[2:4] o_converting)
		else $error("start not taken");
	conv_src_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(o_converting) |-> $past(i_convert_start, 2))
		else $error("spurious conversion");
	conv_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(o_converting) |=> o_converting [*8]) else $error("short");
	cs_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(cs_q && i_convert_start && i_serial_in_mode_select) [*4]
		|-> !o_serial_result_out_oe) else $error("driven while idle");
	cs_open_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		cs_q && rdy_q && $fell(i_convert_start)
		|-> ##[2:4] o_serial_result_out_oe) else $error("not enabled");
	chain_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(!cs_q && rdy_q && i_convert_start) [*4] |-> o_serial_result_out_oe)
		else $error("chain not driven");
	chain_delay_a: assert property (@(posedge i_sck) disable iff (i_rst)
		!cs_q && fall_q >= 5'h10 |-> o_serial_result_out == sh_q[15])
		else $error("chain delay wrong");
endmodule
bind acsp_port acsp_port_chk acsp_port_chk_i (.i_sys_clk(i_sys_clk),
	.i_rst(i_rst), .i_ce(i_ce), .i_sck(i_sck),
	.i_convert_start(i_convert_start),
	.i_serial_in_mode_select(i_serial_in_mode_select),
	.i_sample_level(i_sample_level),
	.o_serial_result_out(o_serial_result_out),
	.o_serial_result_out_oe(o_serial_result_out_oe),
	.o_converting(o_converting));

// [test/tb_acsp_port.sv]
// Self-checking bench for the serial conversion port
`timescale 1ns/1ns
module tb_acsp_port;
	logic i_sys_clk = 1'b0, i_rst = 1'b1, convert_start = 1'b0, sel_q = 1'b1;
	logic chain = 1'b0, go = 1'b0;
	logic signed [17:0] lvl = 18'h00000;
	logic [5:0] nbits = 6'h10;
	logic [15:0] pat = 16'h0000;
	logic sck, up, sout, sout_oe, conv, done;
	logic [31:0] word;
	logic [31:0] exp_q[$];
	int fail_count = 0, tests_run = 0, seed = 97;
	always #5 i_sys_clk = ~i_sys_clk;
	acsp_port acsp_port_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_ce(1'b1), .i_sck(sck), .i_convert_start(convert_start),
		.i_serial_in_mode_select(chain ? up : sel_q), .i_sample_level(lvl),
		.o_serial_result_out(sout), .o_serial_result_out_oe(sout_oe),
		.o_converting(conv));
	acsp_host_model acsp_host_model_i (.i_go(go), .i_nbits(nbits),
		.i_up_pat(pat), .i_sout(sout), .i_sout_oe(sout_oe), .o_sck(sck),
		.o_up(up), .o_word(word), .o_done(done));
	// ==========
	// Tasks
	task automatic complete_run();
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wait_on(input int s, input logic v);
		for (int n = 0; n < 300; n++) begin
			@(posedge i_sys_clk);
			if ((s == 0 ? conv : s == 1 ? sout_oe : exp_q.size() == 0) === v)
				return;
		end
		fail_count++;
		complete_run();
	endtask
	function automatic logic [15:0] sat(input logic signed [17:0] v);
		if (v > 18'sh07fff)
			return 16'h7fff;
		if (v < -18'sh08000)
			return 16'h8000;
		return v[15:0];
	endfunction
	task automatic convert(input logic signed [17:0] v, input logic m);
		@(posedge i_sys_clk);
		convert_start <= 1'b0;
		lvl <= v;
		sel_q <= m;
		chain <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		convert_start <= 1'b1;
		wait_on(0, 1'b1);
	endtask
	task automatic read(input logic [5:0] n, input logic [31:0] e);
		exp_q.push_back(e);
		nbits <= n;
		go <= 1'b1;
		@(posedge i_sys_clk);
		go <= 1'b0;
		wait_on(2, 1'b1);
	endtask
	// ==========
	// Result watcher
	always @(posedge done) begin
		if (exp_q.size() > 0)
			check_word(exp_q.pop_front(), word);
	end
	// ==========
	// Saturation ends, then random levels; odd items arm busy
	initial begin
		logic signed [17:0] v;
		int r;
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			v = k == 0 ? 18'sh1ffff : k == 1 ? 18'sh20000
				: {{2{r[15]}}, r[15:0]};
			convert(v, 1'b1);
			if (k[0])
				convert_start <= 1'b0;
			wait_on(0, 1'b0);
			repeat (5) @(posedge i_sys_clk);
			convert_start <= 1'b0;
			wait_on(1, 1'b1);
			read(k[0] ? 6'h11 : 6'h10, {15'h0, k[0], sat(v)});
			wait_on(1, 1'b0);
		end
		r = $random(seed);
		pat <= r[15:0];
		convert(18'sh00155, 1'b0);
		wait_on(0, 1'b0);
		chain <= 1'b1;
		repeat (5) @(posedge i_sys_clk);
		read(6'h20, {16'h0155, r[15:0]});
		convert_start <= 1'b0;
		complete_run();
	end
endmodule
